// [bench/octal_uart_interrupt_scanner_bench.sv]
/*
 * Self-checking bench for the interrupt scanner: stops, releases, priority and modem summary.
 * Assumes the design package and the host model compiled before it.
 */
`timescale 1ns/1ps
module octal_uart_interrupt_scanner_bench;
    import ouis_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, parity_en = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, irq_b, int_source_is_tx, irq_seen;
    logic [7:0] rxr = 8'h00, rxe = 8'h00, mce = 8'h00, txh = 8'hFF, txe = 8'h00, rbr = 8'h00, thw = 8'h00;
    logic [7:0] dsr = 8'h00, dcd = 8'h00, wdata = 8'h00, rdata, lsc, tae, d, d2;
    logic [2:0] addr = 3'h0, line;
    logic [1:0] dbits = 2'h3, stops = 2'h0;
    int         fails = 0, cmp_count = 0;
    always #4 clk = ~clk;
    ouis_scanner dut (.clk(clk), .rst_b(rst_b), .rx_char_ready(rxr), .rx_int_enable(rxe),
        .modem_change_int_enable(mce), .tx_holding_empty(txh), .tx_int_enable(txe), .rx_buf_read(rbr),
        .tx_hold_write(thw), .dsr_in(dsr), .dcd_in(dcd), .bit_period(16'h0004), .data_bits_sel(dbits),
        .parity_en(parity_en), .stop_sel(stops), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(rdata), .irq_b(irq_b), .interrupting_line_number(line),
        .int_source_is_tx(int_source_is_tx), .line_status_changed(lsc), .tx_all_empty(tae));
    ouis_host_model host (.clk(clk), .rst_b(rst_b), .irq_b(irq_b), .irq_seen(irq_seen));
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic reg_read(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_rd <= 1'b1;
        addr   <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic reg_write(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        addr   <= a;
        wdata  <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // bounded wait on the host's view of the request
    task automatic wait_irq(input logic lvl);
        int n;
        for (n = 0; n < 64 && irq_seen !== lvl; n++) @(posedge clk);
        if (irq_seen !== lvl) begin
            fails++;
            $display("[FAIL] irq wait expected %b seen %b", lvl, irq_seen);
            tally_and_finish();
        end
        #1;
    endtask
    task automatic expect_stop(input logic [2:0] ln, input logic tx);
        wait_irq(1'b1);
        chk("line", {5'h00, line}, {5'h00, ln});
        chk("dir", {7'h00, int_source_is_tx}, {7'h00, tx});
        reg_read(ADDR_INT_SUMMARY, d);
        chk("int summary", d, {1'b1, 3'h0, ln, tx});
    endtask
    task automatic test_rx_ready();
        @(posedge clk);
        rxr[2] <= 1'b1;
        rxe[2] <= 1'b1;
        expect_stop(3'h2, 1'b0);
        @(posedge clk);
        rbr[2] <= 1'b1;
        rxr[2] <= 1'b0;
        @(posedge clk);
        rbr[2] <= 1'b0;
        wait_irq(1'b0);
        chk("irq_b after read", {7'h00, irq_b}, 8'h01);
    endtask
    task automatic test_tx_priority();
        @(posedge clk);
        txe[5] <= 1'b1;
        expect_stop(3'h5, 1'b1);
        @(posedge clk);
        rxr <= 8'hC2;
        rxe <= 8'hC2;
        txe[6] <= 1'b1;
        repeat (20) @(posedge clk);
        chk("held line", {5'h00, line}, 8'h05);
        txe[5] <= 1'b0;
        wait_irq(1'b0);
        expect_stop(3'h1, 1'b0);
        rxe[1] <= 1'b0;
        wait_irq(1'b0);
        expect_stop(3'h6, 1'b0);
        rxe[6] <= 1'b0;
        wait_irq(1'b0);
        expect_stop(3'h7, 1'b0);
        rxe <= 8'h00;
        rxr <= 8'h00;
        wait_irq(1'b0);
        expect_stop(3'h6, 1'b1);
        thw[6] <= 1'b1;
        txe[6] <= 1'b0;
        @(posedge clk);
        thw[6] <= 1'b0;
        wait_irq(1'b0);
    endtask
    task automatic test_modem();
        @(posedge clk);
        dsr[3] <= 1'b1;
        repeat (3) @(posedge clk);
        chk("change flag", lsc, 8'h08);
        reg_read(ADDR_MDM_SUMMARY, d);
        chk("mdm summary top", d & 8'hF0, 8'h80);
        // strobes two clocks apart, so the free counter moved by two
        reg_read(ADDR_MDM_SUMMARY, d2);
        chk("free count step", (d2 - d) & 8'h0F, 8'h02);
        reg_write(ADDR_MDM_SUMMARY, 8'h00);
        repeat (2) @(posedge clk);
        chk("zero write", lsc, 8'h08);
        mce[3] <= 1'b1;
        rxe[3] <= 1'b1;
        expect_stop(3'h3, 1'b0);
        // interrupts handled with the bench's own sequence, write back at once
        reg_write(ADDR_MDM_SUMMARY, 8'h08);
        wait_irq(1'b0);
        chk("flag cleared", lsc, 8'h00);
        mce[3] <= 1'b0;
        rxe[3] <= 1'b0;
        reg_read(3'h5, d);
        chk("unmapped read", d, 8'h00);
    endtask
    // two_chars: (start + data + parity + stop) bits of 4 clocks, twice
    task automatic test_tx_empty(input logic [1:0] dsel, input logic par, input logic [1:0] ssel, input int two_chars);
        @(posedge clk);
        dbits     <= dsel;
        parity_en <= par;
        stops     <= ssel;
        thw[0]    <= 1'b1;
        @(posedge clk);
        thw[0] <= 1'b0;
        repeat (two_chars - 8) @(posedge clk);
        chk("still sending", {7'h00, tae[0]}, 8'h00);
        repeat (16) @(posedge clk);
        chk("all empty", {7'h00, tae[0]}, 8'h01);
    endtask
    // a modem change under reset must not survive; the first one after it must
    task automatic test_reset_midrun();
        @(posedge clk);
        rst_b  <= 1'b0;
        dsr[5] <= 1'b1;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("reset drops change", lsc, 8'h00);
        chk("reset all empty", tae, 8'hFF);
        chk("reset irq_b again", {7'h00, irq_b}, 8'h01);
        @(posedge clk);
        dcd[5] <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk("change after reset", lsc, 8'h20);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        chk("reset irq_b", {7'h00, irq_b}, 8'h01);
        chk("reset flags", lsc, 8'h00);
        chk("reset tx empty", tae, 8'hFF);
        reg_read(ADDR_INT_SUMMARY, d);
        chk("reset summary", d, ISR_RESET);
        test_rx_ready();
        test_tx_priority();
        test_modem();
        // 8 data, no parity, 1 stop: 10 bits; 5 data, parity, 1.5 stop: 8.5 bits
        test_tx_empty(2'h3, 1'b0, 2'h0, 80);
        test_tx_empty(2'h0, 1'b1, 2'h1, 68);
        test_reset_midrun();
        tally_and_finish();
    end
endmodule // octal_uart_interrupt_scanner_bench

// [bench/ouis_host_model.sv]
/*
 * Host processor model: senses the active-low request as a level and flags it.
 * Assumes the scanner's clock and synchronous active-low reset.
 */
`timescale 1ns/1ps
module ouis_host_model (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic irq_b,
    output logic      irq_seen
);
    // level sensing: an edge-only host would miss a modem stop that stays low
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq_seen <= 1'b0;
        end else begin
            irq_seen <= !irq_b;
        end
    end
endmodule // ouis_host_model

// [core/ouis_char_timer.sv]
/*
 * Character timer: after the last holding-register load, counts up to two
 * character times and then flags the transmitter as completely empty.
 * Assumes bit period in clocks is supplied by the baud logic outside.
 */
`timescale 1ns/1ps
module ouis_char_timer
    import ouis_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire logic                 thr_load,
    input  wire logic                 holding_empty,
    input  wire logic [BIT_CNT_W-1:0] bit_period,
    input  wire logic [1:0]           data_bits_sel,
    input  wire logic                 parity_en,
    input  wire logic [1:0]           stop_sel,
    output logic                      all_empty
);
    logic [CHAR_CNT_W-1:0] remain_r;
    logic [CHAR_CNT_W-1:0] char_len;
    logic [4:0]            half_bits;
    logic [4:0]            stop_half;
    logic [CHAR_CNT_W-1:0] half_period;

    // stop 0:1 bit, 1:1.5 bits, 2 or 3:2 bits, counted in halves
    always_comb begin
        stop_half = (stop_sel == 2'h0) ? 5'h02 : ((stop_sel == 2'h1) ? 5'h03 : 5'h04);
        half_bits = CHAR_HALF_START + 5'((5 + 32'(data_bits_sel)) * 2)
                    + (parity_en ? 5'h02 : 5'h00) + stop_half;
        half_period = CHAR_CNT_W'(bit_period[BIT_CNT_W-1:1]);
        char_len    = CHAR_CNT_W'(half_period * CHAR_CNT_W'(half_bits));
    end

    // a fresh load restarts the full two-character wait
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            remain_r <= '0;
        end else if (thr_load) begin
            remain_r <= CHAR_CNT_W'(char_len * CHAR_CNT_W'(TX_EMPTY_CHARS));
        end else if (remain_r != '0) begin
            remain_r <= remain_r - CHAR_CNT_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            all_empty <= 1'b1;
        end else begin
            all_empty <= holding_empty && (remain_r == '0) && !thr_load;
        end
    end

    chk_empty_after_load: assert property (@(posedge clk) disable iff (!rst_b)
        thr_load |=> !all_empty) else $error("tx_all_empty set right after a load");
endmodule // ouis_char_timer

// [core/ouis_pkg.sv]
/*
 * Package for the octal serial interrupt scanner: register layouts, reset values,
 * scan positions and character-time figures.
 * Assumes a single 125 MHz clock domain.
 */
package ouis_pkg;
    localparam int          NUM_LINES        = 8;
    localparam int          SCAN_W           = 4;
    localparam logic [3:0]  SCAN_FIRST_TX    = 4'h8;
    localparam logic [3:0]  SCAN_RESET       = 4'h0;
    // interrupt summary register
    localparam int          ISR_REQ_BIT      = 7;
    localparam int          ISR_LINE_LSB     = 1;
    localparam int          ISR_DIR_BIT      = 0;
    localparam logic [7:0]  ISR_RESET        = 8'h00;
    // modem change summary register
    localparam int          MCS_VALID_BIT    = 7;
    localparam logic [7:0]  MCS_RESET        = 8'h00;
    // register selects on the plain port
    localparam logic [2:0]  ADDR_INT_SUMMARY = 3'h0;
    localparam logic [2:0]  ADDR_MDM_SUMMARY = 3'h1;
    // character time: start + data + parity + stop, in half bit periods
    localparam logic [4:0]  CHAR_HALF_START  = 5'h02;
    localparam int          TX_EMPTY_CHARS   = 2;
    localparam int          BIT_CNT_W        = 16;
    localparam int          CHAR_CNT_W       = 24;
endpackage

// [core/ouis_scanner.sv]
/*
 * Interrupt scanner of an eight-line serial controller with modem change summary.
 * Assumes per-line flags and service strobes come synchronous from the line logic;
 * registers reached over a plain port, read data one cycle after the read strobe.
 */
// Functional notes
// - modem change summary bits clear only where software writes a one.
// - low four summary bits show a free counter, valid only with bit 7 set.
// - reset holds change logic cleared; afterwards input changes are recorded.
// - 4-bit scan: positions 0-7 receivers, 8-15 transmitters of lines 0-7.
// - a pending condition stops the scanner and pulls the request low.
// - while stopped and unserviced no other request is posted.
// - receiver condition: ready with rx enable, or change with both enables.
// - transmitter condition: holding empty with tx enable.
// - on stop show line number, direction pin, and update interrupt summary.
// - receive-ready released by buffer read or rx enable cleared.
// - modem change released by clearing either enable or the change flag.
// - transmitter released by holding load or tx enable cleared.
// - after a receiver stop scanning resumes from the position after the stop.
// - after a transmitter stop scanning restarts from position 0.
// - tx_all_empty only after holding and serializer empty, up to two chars.
// - character time is start, data, optional parity and stop bits.
// - summary: bit 7 request, 6-4 zero, 3-1 line, bit 0 transmitter.
`timescale 1ns/1ps
module ouis_scanner
    import ouis_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire logic [NUM_LINES-1:0] rx_char_ready,
    input  wire logic [NUM_LINES-1:0] rx_int_enable,
    input  wire logic [NUM_LINES-1:0] modem_change_int_enable,
    input  wire logic [NUM_LINES-1:0] tx_holding_empty,
    input  wire logic [NUM_LINES-1:0] tx_int_enable,
    input  wire logic [NUM_LINES-1:0] rx_buf_read,
    input  wire logic [NUM_LINES-1:0] tx_hold_write,
    input  wire logic [NUM_LINES-1:0] dsr_in,
    input  wire logic [NUM_LINES-1:0] dcd_in,
    input  wire logic [BIT_CNT_W-1:0] bit_period,
    input  wire logic [1:0]           data_bits_sel,
    input  wire logic                 parity_en,
    input  wire logic [1:0]           stop_sel,
    input  wire logic [2:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic [7:0]                reg_rdata,
    output logic                      irq_b,
    output logic [2:0]                interrupting_line_number,
    output logic                      int_source_is_tx,
    output logic [NUM_LINES-1:0]      line_status_changed,
    output logic [NUM_LINES-1:0]      tx_all_empty
);
    typedef enum logic [1:0] {
        OUIS_SCAN  = 2'b00,
        OUIS_RX_CHAR_READY = 2'b01,
        OUIS_MDM   = 2'b10,
        OUIS_TX    = 2'b11
    } ouis_state_t;

    ouis_state_t          state_r;
    logic [SCAN_W-1:0]    pos_r;
    logic [3:0]           free_cnt_r;
    logic [NUM_LINES-1:0] dsr_r;
    logic [NUM_LINES-1:0] dcd_r;
    logic                 mdm_armed_r;
    logic [7:0]           int_sum_r;
    logic [NUM_LINES-1:0] rx_rdy_cond;
    logic [NUM_LINES-1:0] mdm_cond;
    logic [NUM_LINES-1:0] tx_cond;
    logic [NUM_LINES-1:0] chg_evt;
    logic [NUM_LINES-1:0] mcs_clr;
    logic [2:0]           line;
    logic                 hit_rx_rdy;
    logic                 hit_mdm;
    logic                 hit_tx;
    logic                 released;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_LINES; gi++) begin : g_line
            assign rx_rdy_cond[gi] = rx_char_ready[gi] && rx_int_enable[gi];
            assign mdm_cond[gi]    = line_status_changed[gi] && rx_int_enable[gi]
                                     && modem_change_int_enable[gi];
            assign tx_cond[gi]     = tx_holding_empty[gi] && tx_int_enable[gi];
            assign chg_evt[gi]     = mdm_armed_r && ((dsr_in[gi] != dsr_r[gi]) || (dcd_in[gi] != dcd_r[gi]));
            assign mcs_clr[gi]     = reg_wr && (reg_addr == ADDR_MDM_SUMMARY)
                                     && reg_wdata[gi];

            // a change in the clearing cycle survives: set beats clear
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    line_status_changed[gi] <= 1'b0;
                end else if (chg_evt[gi]) begin
                    line_status_changed[gi] <= 1'b1;
                end else if (mcs_clr[gi]) begin
                    line_status_changed[gi] <= 1'b0;
                end
            end

            // per-line checks, so every line's flag is covered, not only line 0
            chk_w1c_clear: assert property (@(posedge clk) disable iff (!rst_b)
                (mcs_clr[gi] && !chg_evt[gi]) |=> !line_status_changed[gi])
                else $error("write one did not clear change bit");
            chk_zero_keeps: assert property (@(posedge clk) disable iff (!rst_b)
                (line_status_changed[gi] && !mcs_clr[gi]) |=> line_status_changed[gi])
                else $error("change bit lost without write one");
            chk_change_sets: assert property (@(posedge clk) disable iff (!rst_b)
                chg_evt[gi] |=> line_status_changed[gi])
                else $error("modem input change not recorded");

            ouis_char_timer u_timer (
                .clk           (clk),
                .rst_b         (rst_b),
                .thr_load      (tx_hold_write[gi]),
                .holding_empty (tx_holding_empty[gi]),
                .bit_period    (bit_period),
                .data_bits_sel (data_bits_sel),
                .parity_en     (parity_en),
                .stop_sel      (stop_sel),
                .all_empty     (tx_all_empty[gi])
            );
        end
    endgenerate

    // first cycle after reset only samples the lines, so no false change
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mdm_armed_r <= 1'b0;
            dsr_r       <= '0;
            dcd_r       <= '0;
        end else begin
            mdm_armed_r <= 1'b1;
            dsr_r       <= dsr_in;
            dcd_r       <= dcd_in;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            free_cnt_r <= 4'h0;
        end else begin
            free_cnt_r <= free_cnt_r + 4'h1;
        end
    end

    assign line       = pos_r[2:0];
    assign hit_rx_rdy = !pos_r[3] && rx_rdy_cond[line];
    assign hit_mdm    = !pos_r[3] && mdm_cond[line];
    assign hit_tx     = pos_r[3] && tx_cond[line];

    // release: an enable was cleared or the service strobe came; a modem stop releases once its condition goes away
    always_comb begin
        case (state_r)
            OUIS_RX_CHAR_READY: released = rx_buf_read[line] || !rx_int_enable[line];
            OUIS_MDM:   released = !mdm_cond[line];
            OUIS_TX:    released = tx_hold_write[line] || !tx_int_enable[line];
            default:    released = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_r <= OUIS_SCAN;
            pos_r   <= SCAN_RESET;
        end else begin
            case (state_r)
                OUIS_SCAN: begin
                    if (hit_rx_rdy) begin
                        state_r <= OUIS_RX_CHAR_READY;
                    end else if (hit_mdm) begin
                        state_r <= OUIS_MDM;
                    end else if (hit_tx) begin
                        state_r <= OUIS_TX;
                    end else begin
                        pos_r <= pos_r + 4'h1;
                    end
                end
                OUIS_RX_CHAR_READY, OUIS_MDM: begin
                    if (released) begin
                        state_r <= OUIS_SCAN;
                        pos_r   <= pos_r + 4'h1;
                    end
                end
                OUIS_TX: begin
                    if (released) begin
                        state_r <= OUIS_SCAN;
                        pos_r   <= SCAN_RESET;
                    end
                end
                default: begin
                    state_r <= OUIS_SCAN;
                end
            endcase
        end
    end

    // request pins track the stop state, held until release
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq_b                    <= 1'b1;
            interrupting_line_number <= 3'h0;
            int_source_is_tx         <= 1'b0;
            int_sum_r                <= ISR_RESET;
        end else if (state_r == OUIS_SCAN && (hit_rx_rdy || hit_mdm || hit_tx)) begin
            irq_b                    <= 1'b0;
            interrupting_line_number <= line;
            int_source_is_tx         <= pos_r[3];
            int_sum_r                <= {1'b1, 3'h0, line, pos_r[3]};
        end else if (state_r != OUIS_SCAN && released) begin
            irq_b                    <= 1'b1;
            int_sum_r[ISR_REQ_BIT]   <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                ADDR_INT_SUMMARY: reg_rdata <= int_sum_r;
                ADDR_MDM_SUMMARY: reg_rdata <= {|line_status_changed, 3'h0, free_cnt_r};
                default:          reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    chk_stop_holds_irq: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r != OUIS_SCAN && !released) |=> (!irq_b && $stable(interrupting_line_number)))
        else $error("request moved while stopped");
    chk_stop_drives_irq: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r == OUIS_SCAN && hit_rx_rdy) |=> (!irq_b && !int_source_is_tx && $stable(pos_r)))
        else $error("receiver hit did not stop scanner");
    chk_tx_restart_zero: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r == OUIS_TX && released) |=> (pos_r == 4'h0 && irq_b))
        else $error("transmitter release not back to position 0");
    chk_rx_resume_next: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r == OUIS_RX_CHAR_READY && released) |=> (pos_r == $past(pos_r) + 4'h1))
        else $error("receiver release not resuming sequentially");
    chk_scan_step: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r == OUIS_SCAN && !hit_rx_rdy && !hit_mdm && !hit_tx) |=> pos_r == $past(pos_r) + 4'h1)
        else $error("idle scanner did not step");
    chk_summary_match: assert property (@(posedge clk) disable iff (!rst_b)
        !irq_b |-> (int_sum_r[7:4] == 4'h8 && int_sum_r[3:1] == interrupting_line_number
                    && int_sum_r[0] == int_source_is_tx))
        else $error("summary register disagrees with pins");
    chk_quiet_after_reset: assert property (@(posedge clk) disable iff (!rst_b)
        !mdm_armed_r |=> line_status_changed == 8'h00)
        else $error("change recorded in first cycle after reset");
    chk_free_count: assert property (@(posedge clk) disable iff (!rst_b)
        1'b1 |=> free_cnt_r == $past(free_cnt_r) + 4'h1)
        else $error("free counter did not step");

    // register port answers
    chk_rdata_idle: assert property (@(posedge clk) disable iff (!rst_b)
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    chk_mdm_read: assert property (@(posedge clk) disable iff (!rst_b)
        (reg_rd && reg_addr == ADDR_MDM_SUMMARY) |=> (reg_rdata[6:4] == 3'h0
            && reg_rdata[MCS_VALID_BIT] == ($past(line_status_changed) != 8'h00)))
        else $error("modem summary read wrong");
    chk_rdata_int: assert property (@(posedge clk) disable iff (!rst_b)
        (reg_rd && reg_addr == ADDR_INT_SUMMARY) |=> reg_rdata == $past(int_sum_r))
        else $error("interrupt summary read wrong");

    // stop, release and resume
    chk_irq_tracks_stop: assert property (@(posedge clk) disable iff (!rst_b)
        irq_b == (state_r == OUIS_SCAN))
        else $error("request pin and scanner state disagree");
    chk_stop_keeps_pos: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r != OUIS_SCAN && !released) |=> $stable(pos_r))
        else $error("scanner moved while stopped");
    chk_mdm_stop: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r == OUIS_SCAN && !hit_rx_rdy && hit_mdm) |=> (state_r == OUIS_MDM && !irq_b))
        else $error("modem change did not stop scanner");
    chk_line_reported: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r == OUIS_SCAN && (hit_rx_rdy || hit_mdm || hit_tx))
            |=> (interrupting_line_number == $past(line) && int_sum_r[3:1] == $past(line)))
        else $error("stop line not reported");
    chk_rx_release: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r == OUIS_RX_CHAR_READY && rx_buf_read[line]) |=> (irq_b && state_r == OUIS_SCAN))
        else $error("buffer read did not release request");
    chk_mdm_release: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r == OUIS_MDM && !mdm_cond[line]) |=> (irq_b && state_r == OUIS_SCAN))
        else $error("modem condition gone but request held");
    chk_tx_release: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r == OUIS_TX && tx_hold_write[line]) |=> (irq_b && pos_r == SCAN_RESET))
        else $error("holding load did not release request");
    chk_mdm_resume_next: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r == OUIS_MDM && released) |=> (pos_r == $past(pos_r) + 4'h1))
        else $error("modem release not resuming sequentially");
    chk_summary_clear: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r != OUIS_SCAN && released) |=> !int_sum_r[ISR_REQ_BIT])
        else $error("summary request bit kept after release");
    chk_tx_pin_dir: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r == OUIS_SCAN && hit_tx) |=> (int_source_is_tx && !irq_b))
        else $error("transmitter stop without direction pin");

    cov_rx_stop: cover property (@(posedge clk) disable iff (!rst_b) state_r == OUIS_RX_CHAR_READY && released);
    cov_mdm_stop: cover property (@(posedge clk) disable iff (!rst_b) state_r == OUIS_MDM && released);
    cov_tx_stop: cover property (@(posedge clk) disable iff (!rst_b) state_r == OUIS_TX && released);
    cov_wrap: cover property (@(posedge clk) disable iff (!rst_b) pos_r == 4'hF ##1 pos_r == 4'h0);
    cov_rx_chain: cover property (@(posedge clk) disable iff (!rst_b)
        (state_r == OUIS_RX_CHAR_READY && released) ##2 state_r == OUIS_RX_CHAR_READY);
endmodule // ouis_scanner
